// ---- gpc_pkg.sv ----
// gpc_pkg: shared constants of the gpio pin control port
// assumes: one 8-pin port, byte-wide register port
package gpc_pkg;
  localparam int PIN_N = 8;
  localparam int ADDR_W = 3;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_DIR = 3'h1;
  localparam logic [2:0] OFF_PULL = 3'h2;
  localparam logic [2:0] OFF_SLEW = 3'h3;
  localparam logic [2:0] OFF_DRIVE = 3'h4;
  localparam logic [2:0] OFF_PWR = 3'h5;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] RST_SLEW = 8'hff;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  // ------------------------------------------------------------
  // power_mode_status_control fields
  // ------------------------------------------------------------
  localparam int PWR_FLAG_BIT = 0;
  localparam int PWR_ACK_BIT = 1;
  localparam int PWR_BLK_BIT = 2;
  localparam int PWR_RET_BIT = 3;
  // oscillator pins (port_g_pin_five / port_g_pin_six)
  localparam int OSC_OUT_PIN = 5;
  localparam int OSC_IN_PIN = 6;
endpackage : gpc_pkg

// ---- gpc_pin_if.sv ----
// gpc_pin_if: per-pin controls from the register file to the pin mux
// assumes: both ends on sys_clk, all fields but the 1-bit osc_en 8 bits one per pin
`timescale 1ns/10ps
`default_nettype none
interface gpc_pin_if;
  logic [7:0] dir;
  logic [7:0] data;
  logic [7:0] pull;
  logic [7:0] slew;
  logic [7:0] drive;
  logic [7:0] per_en;
  logic [7:0] per_oe;
  logic [7:0] per_out;
  logic [7:0] ana_en;
  logic [7:0] key_in_en;
  logic osc_en;
  logic [7:0] oe;
  logic [7:0] out;
  logic [7:0] pu_on;
  logic [7:0] se_on;
  logic [7:0] hd_on;
  modport ctl(output dir, data, pull, slew, drive, per_en, per_oe,
    per_out, ana_en, key_in_en, osc_en, input oe, out, pu_on, se_on,
    hd_on);
  modport mux(input dir, data, pull, slew, drive, per_en, per_oe,
    per_out, ana_en, key_in_en, osc_en, output oe, out, pu_on, se_on,
    hd_on);
endinterface : gpc_pin_if
`default_nettype wire

// ---- gpc_sync.sv ----
// gpc_sync: two-flop synchroniser for the pin levels
// assumes: pins change without regard to sys_clk
`timescale 1ns/10ps
`default_nettype none
module gpc_sync (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] async_in,
  output logic [7:0] sync_out
);
  logic [7:0] meta_ff;
  logic [7:0] sync_ff;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_ff <= gpc_pkg::ZERO8;
      sync_ff <= gpc_pkg::ZERO8;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : gpc_sync
`default_nettype wire

// ---- gpc_pin_mux.sv ----
// gpc_pin_mux: per-pin ownership and pad control decode
// assumes: register controls come registered, peripheral and mode controls straight from the ports; result is registered by the caller
`timescale 1ns/10ps
`default_nettype none
module gpc_pin_mux (
  gpc_pin_if.mux pif
);
  function automatic logic is_osc_pin(input int idx);
    is_osc_pin = (idx == gpc_pkg::OSC_OUT_PIN) ||
      (idx == gpc_pkg::OSC_IN_PIN);
  endfunction : is_osc_pin

  genvar i;
  generate
    for (i = 0; i < gpc_pkg::PIN_N; i++) begin : g_pin
      logic osc;
      logic oe;
      assign osc = pif.osc_en && is_osc_pin(i);
      // analog outranks every digital owner, oscillator outranks port
      always_comb begin
        if (osc || pif.ana_en[i]) begin
          oe = 1'b0;
        end else if (pif.key_in_en[i]) begin
          oe = 1'b0;
        end else if (pif.per_en[i]) begin
          oe = pif.per_oe[i];
        end else begin
          oe = pif.dir[i];
        end
      end
      assign pif.oe[i] = oe;
      assign pif.out[i] = pif.per_en[i] ? pif.per_out[i] : pif.data[i];
      assign pif.pu_on[i] = pif.pull[i] && !oe && !osc &&
        !pif.ana_en[i];
      assign pif.se_on[i] = pif.slew[i] && oe;
      assign pif.hd_on[i] = pif.drive[i] && !osc;
    end
  endgenerate
endmodule : gpc_pin_mux
`default_nettype wire

// ---- gpc_port.sv ----
// gpc_port: 8-pin general purpose port with pin control and stop
// handling, registers on a plain strobe port with one-cycle read data.
// assumes: peripheral and mode inputs synchronous to sys_clk; pad
// tristate/pull/slew/drive cells sit outside and obey the outputs.
//
// Summary of operation
// - direction 0: driver off, read pin level
// - direction 1: driver on, read latched data
// - one direction bit per pin, both jobs
// - direction bit picks read source under peripheral
// - enabled peripheral owns direction and output value
// - analog owner: digital off, reads zero
// - analog beats digital alternate function
// - keyboard input pin is always input
// - oscillator takes pins five and six
// - pin control separate from data/direction
// - pullup on only when pin not output
// - pullup off under analog ownership
// - slew limit only matters for outputs
// - drive bit selects high or low drive
// - partial power-down holds pins; software checks flag
// - I/O blocked until acknowledge written after wake
// - retained-logic stop keeps state, resumes at once
// - reset: inputs, no pullup, slew on, low drive
// - data write latches all bits always; the code drops data writes while blocked after wake
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module gpc_port (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pad_pullup,
  output logic [7:0] pad_slew_limit,
  output logic [7:0] pad_high_drive,
  output logic [7:0] periph_in,
  input wire logic [7:0] periph_en,
  input wire logic [7:0] periph_oe,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] analog_en,
  input wire logic [7:0] key_in_en,
  input wire logic osc_en,
  input wire logic partial_powerdown_stop,
  input wire logic retained_logic_stop
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] data_ff;
  logic [7:0] dir_ff;
  logic [7:0] pull_ff;
  logic [7:0] slew_ff;
  logic [7:0] drive_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic [7:0] pin_sync;
  logic pd_stop_d_ff;
  logic ppd_flag_ff;
  logic blocked_ff;
  logic wake;
  logic ack_wr;
  logic hold;
  logic io_wr;
  logic [7:0] out_ff;
  logic [7:0] oe_ff;
  logic [7:0] pu_ff;
  logic [7:0] se_ff;
  logic [7:0] hd_ff;

  gpc_pin_if pif ();

  // ------------------------------------------------------------
  // pin input synchroniser and pin mux
  // ------------------------------------------------------------
  gpc_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in(pad_in),
    .sync_out(pin_sync)
  );

  assign pif.dir = dir_ff;
  assign pif.data = data_ff;
  assign pif.pull = pull_ff;
  assign pif.slew = slew_ff;
  assign pif.drive = drive_ff;
  assign pif.per_en = periph_en;
  assign pif.per_oe = periph_oe;
  assign pif.per_out = periph_out;
  assign pif.ana_en = analog_en;
  assign pif.key_in_en = key_in_en;
  assign pif.osc_en = osc_en;

  gpc_pin_mux u_mux (
    .pif(pif)
  );

  // ------------------------------------------------------------
  // stop handling
  // ------------------------------------------------------------
  // wake from partial power-down is the falling edge of the mode level;
  // the retained-logic stop needs nothing: all state simply stays
  assign wake = pd_stop_d_ff && !partial_powerdown_stop;
  assign ack_wr = reg_wr && (reg_addr == gpc_pkg::OFF_PWR) &&
    reg_wdata[gpc_pkg::PWR_ACK_BIT];
  // wake edge holds too: blocked_ff only rises after it
  assign hold = partial_powerdown_stop || wake ||
    blocked_ff;
  assign io_wr = reg_wr && !blocked_ff;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pd_stop_d_ff <= 1'b0;
    end else begin
      pd_stop_d_ff <= partial_powerdown_stop;
    end
  end

  // set wins over the acknowledge clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ppd_flag_ff <= 1'b0;
      blocked_ff <= 1'b0;
    end else if (wake) begin
      ppd_flag_ff <= 1'b1;
      blocked_ff <= 1'b1;
    end else if (ack_wr) begin
      ppd_flag_ff <= 1'b0;
      blocked_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // parallel I/O registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      data_ff <= gpc_pkg::RST_DATA;
    end else if (io_wr && reg_addr == gpc_pkg::OFF_DATA) begin
      data_ff <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dir_ff <= gpc_pkg::RST_DIR;
    end else if (io_wr && reg_addr == gpc_pkg::OFF_DIR) begin
      dir_ff <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // pin control registers, own decode only
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pull_ff <= gpc_pkg::RST_PULL;
      slew_ff <= gpc_pkg::RST_SLEW;
      drive_ff <= gpc_pkg::RST_DRIVE;
    end else if (io_wr) begin
      if (reg_addr == gpc_pkg::OFF_PULL) begin
        pull_ff <= reg_wdata;
      end
      if (reg_addr == gpc_pkg::OFF_SLEW) begin
        slew_ff <= reg_wdata;
      end
      if (reg_addr == gpc_pkg::OFF_DRIVE) begin
        drive_ff <= reg_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    nxt_rd_data = gpc_pkg::ZERO8;
    if (reg_addr == gpc_pkg::OFF_PWR) begin
      nxt_rd_data[gpc_pkg::PWR_FLAG_BIT] = ppd_flag_ff;
      nxt_rd_data[gpc_pkg::PWR_BLK_BIT] = blocked_ff;
      nxt_rd_data[gpc_pkg::PWR_RET_BIT] = retained_logic_stop;
    end else if (!blocked_ff) begin
      unique case (reg_addr)
        gpc_pkg::OFF_DATA: begin
          // direction picks source even under peripheral ownership
          nxt_rd_data = ((dir_ff & data_ff) | (~dir_ff & pin_sync)) &
            ~analog_en;
        end
        gpc_pkg::OFF_DIR: begin
          nxt_rd_data = dir_ff;
        end
        gpc_pkg::OFF_PULL: begin
          nxt_rd_data = pull_ff;
        end
        gpc_pkg::OFF_SLEW: begin
          nxt_rd_data = slew_ff;
        end
        gpc_pkg::OFF_DRIVE: begin
          nxt_rd_data = drive_ff;
        end
        default: begin
          nxt_rd_data = gpc_pkg::ZERO8;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rd_data_ff <= gpc_pkg::ZERO8;
    end else if (reg_rd) begin
      rd_data_ff <= nxt_rd_data;
    end else begin
      rd_data_ff <= gpc_pkg::ZERO8;
    end
  end

  assign reg_rdata = rd_data_ff;

  // ------------------------------------------------------------
  // pad outputs, frozen while power-down latches hold
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      out_ff <= gpc_pkg::ZERO8;
      oe_ff <= gpc_pkg::ZERO8;
      pu_ff <= gpc_pkg::ZERO8;
      se_ff <= gpc_pkg::ZERO8;
      hd_ff <= gpc_pkg::ZERO8;
    end else if (!hold) begin
      out_ff <= pif.out;
      oe_ff <= pif.oe;
      pu_ff <= pif.pu_on;
      se_ff <= pif.se_on;
      hd_ff <= pif.hd_on;
    end
  end

  assign pad_out = out_ff;
  assign pad_oe = oe_ff;
  assign pad_pullup = pu_ff;
  assign pad_slew_limit = se_ff;
  assign pad_high_drive = hd_ff;
  // analog pins feed no digital logic
  assign periph_in = pin_sync & ~analog_en;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_rd_pin;
    @(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == gpc_pkg::OFF_DATA && !blocked_ff |=>
      ((reg_rdata ^ $past(pin_sync)) & $past(~dir_ff & ~analog_en)) == 0;
  endproperty
  a_rd_pin: assert property (p_rd_pin)
    else $error("input pin read not pin level");

  property p_rd_latch;
    @(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == gpc_pkg::OFF_DATA && !blocked_ff |=>
      ((reg_rdata ^ $past(data_ff)) & $past(dir_ff & ~analog_en)) == 0;
  endproperty
  a_rd_latch: assert property (p_rd_latch)
    else $error("output pin read not latched data");

  property p_rd_ana;
    @(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == gpc_pkg::OFF_DATA |=>
      (reg_rdata & $past(analog_en)) == 0;
  endproperty
  a_rd_ana: assert property (p_rd_ana)
    else $error("analog pin read not zero");

  property p_pu_out;
    @(posedge sys_clk) disable iff (!resetn)
    (pad_pullup & pad_oe) == 0;
  endproperty
  a_pu_out: assert property (p_pu_out)
    else $error("pullup on a driven pin");

  property p_pu_ana;
    @(posedge sys_clk) disable iff (!resetn)
    !hold |=> (pad_pullup & $past(analog_en)) == 0;
  endproperty
  a_pu_ana: assert property (p_pu_ana)
    else $error("pullup on analog pin");

  property p_key_in;
    @(posedge sys_clk) disable iff (!resetn)
    !hold |=> (pad_oe & $past(key_in_en)) == 0;
  endproperty
  a_key_in: assert property (p_key_in)
    else $error("keyboard pin driven");

  property p_osc;
    @(posedge sys_clk) disable iff (!resetn)
    osc_en && !hold |=> !pad_oe[gpc_pkg::OSC_OUT_PIN] &&
      !pad_oe[gpc_pkg::OSC_IN_PIN] && !pad_pullup[gpc_pkg::OSC_IN_PIN];
  endproperty
  a_osc: assert property (p_osc)
    else $error("port drives oscillator pin");

  property p_hold;
    @(posedge sys_clk) disable iff (!resetn)
    hold |=> $stable(pad_out) && $stable(pad_oe) && $stable(pad_pullup);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pins moved while held");

  property p_block;
    @(posedge sys_clk) disable iff (!resetn)
    blocked_ff && reg_wr && !ack_wr |=> blocked_ff && $stable(dir_ff)
      && $stable(data_ff);
  endproperty
  a_block: assert property (p_block)
    else $error("I/O written before acknowledge");

  property p_latch;
    @(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == gpc_pkg::OFF_DATA && !blocked_ff |=>
      data_ff == $past(reg_wdata);
  endproperty
  a_latch: assert property (p_latch)
    else $error("data write not latched");
endmodule : gpc_port
`default_nettype wire

// ---- gpc_pin_model.sv ----
// gpc_pin_model: board side of the eight port pins
// assumes: pads come from gpc_port, external levels from the bench
`timescale 1ns/10ps
`default_nettype none
module gpc_pin_model (
  input wire logic sys_clk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] ext_lvl,
  input wire logic [7:0] ext_drv,
  output logic [7:0] pad_in
);
  logic [7:0] float_ff = 8'h55;

  // a floating pin wanders so it never reads as a steady level
  always @(posedge sys_clk) begin
    float_ff <= ~float_ff;
  end

  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_lvl)
    | (~pad_oe & ~ext_drv & pad_pullup)
    | (~pad_oe & ~ext_drv & ~pad_pullup & float_ff);
endmodule : gpc_pin_model
`default_nettype wire

// ---- tb_top.sv ----
// tb_top: self-checking bench for gpc_port against a bench model
// assumes: gpc_pin_model on the pins; bench drives the peripherals
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic resetn;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pad_in, pad_out, pad_oe;
  logic reg_wr, reg_rd, osc_en, pd_stop, rt_stop, m_blk;
  logic [7:0] pad_pullup, pad_slew_limit, pad_high_drive, periph_in;
  logic [7:0] periph_en, periph_oe, periph_out, analog_en, key_in_en;
  logic [7:0] ext_lvl, ext_drv, rs, v;
  logic [7:0] m_data, m_dir, m_pull, m_slew, m_drive;
  logic [7:0] r [7];
  logic [31:0] snap;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;

  always #25 sys_clk = ~sys_clk;

  gpc_port u_gpc_port (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .pad_slew_limit(pad_slew_limit), .pad_high_drive(pad_high_drive),
    .periph_in(periph_in), .periph_en(periph_en), .periph_oe(periph_oe),
    .periph_out(periph_out), .analog_en(analog_en),
    .key_in_en(key_in_en),
    .osc_en(osc_en), .partial_powerdown_stop(pd_stop),
    .retained_logic_stop(rt_stop));

  gpc_pin_model u_gpc_pin_model (.sys_clk(sys_clk), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup(pad_pullup), .ext_lvl(ext_lvl),
    .ext_drv(ext_drv), .pad_in(pad_in));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic complete_run;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] roll();
    rs = {rs[6:0], rs[7] ^ rs[5] ^ rs[4] ^ rs[3]};
    return rs;
  endfunction : roll

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : idle

  // model follows the write unless the port is blocked after a wake
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (!m_blk) begin
      case (a)
        gpc_pkg::OFF_DATA: m_data = d;
        gpc_pkg::OFF_DIR: m_dir = d;
        gpc_pkg::OFF_PULL: m_pull = d;
        gpc_pkg::OFF_SLEW: m_slew = d;
        gpc_pkg::OFF_DRIVE: m_drive = d;
        default: ;
      endcase
    end
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // ------------------------------------------------------------
  // pad and register model
  // ------------------------------------------------------------
  task automatic check_all(input logic [7:0] pwr_exp);
    logic [7:0] oscm, eoe, eout, lvl, msk, d;
    logic [7:0] ex [8];
    oscm = osc_en ? ((8'h01 << gpc_pkg::OSC_OUT_PIN)
      | (8'h01 << gpc_pkg::OSC_IN_PIN)) : 8'h00;
    eoe = ~analog_en & ~oscm & ~key_in_en
      & ((periph_en & periph_oe) | (~periph_en & m_dir));
    eout = (periph_en & periph_out) | (~periph_en & m_data);
    lvl = (eoe & eout) | (~eoe & ext_drv & ext_lvl) | (~eoe & ~ext_drv);
    lvl = lvl & ~oscm;
    chk("pad_oe", pad_oe, eoe);
    chk("pad_out", pad_out & eoe, eout & eoe);
    msk = m_pull & ~eoe & ~analog_en & ~oscm;
    chk("pad_pullup", pad_pullup, msk);
    chk("pad_slew", pad_slew_limit, m_slew & eoe);
    d = m_drive & ~oscm & ~analog_en;
    chk("pad_drive", pad_high_drive & ~analog_en, d);
    chk("periph_in", periph_in & ~oscm, lvl & ~analog_en);
    ex = '{((m_dir & m_data) | (~m_dir & lvl)) & ~analog_en, m_dir,
      m_pull, m_slew, m_drive, pwr_exp, 8'h00, 8'h00};
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      msk = (a == 0) ? ~oscm : 8'hff;
      chk("reg_rdata", d & msk, ex[a] & msk);
    end
  endtask : check_all

  task automatic do_reset;
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    {m_data, m_dir, m_pull, m_drive} = 32'h0000_0000;
    m_slew = 8'hff;
    m_blk = 1'b0;
    idle(5);
    check_all(8'h00);
  endtask : do_reset

  task automatic chk_frozen;
    chk("held_out", pad_out, snap[31:24]);
    chk("held_oe", pad_oe, snap[23:16]);
    chk("held_pullup", pad_pullup, snap[15:8]);
    chk("held_slew", pad_slew_limit, snap[7:0]);
  endtask : chk_frozen

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 13'h0000;
    {periph_en, periph_oe, periph_out, analog_en, key_in_en} = 40'h00_0000_0000;
    {osc_en, pd_stop, rt_stop, m_blk} = 4'h0;
    ext_lvl = 8'ha5;
    ext_drv = 8'hff;
    rs = 8'h4a;
    do_reset();
    for (int i = 0; i < 40; i++) begin
      for (int a = 0; a < 8; a++) begin
        v = roll();
        if (a != 5) wr(a[2:0], v); // data goes in before direction
      end
      for (int k = 0; k < 7; k++) r[k] = roll();
      @(posedge sys_clk);
      periph_en <= r[0];
      periph_oe <= r[1];
      periph_out <= r[2];
      analog_en <= r[3] & r[4];
      key_in_en <= r[4] & r[5];
      osc_en <= r[6][0];
      ext_lvl <= r[5];
      ext_drv <= r[6] | ~m_pull;
      idle(5);
      check_all(8'h00);
    end
    // partial power-down: pads hold from entry until the ack
    @(posedge sys_clk);
    pd_stop <= 1'b1;
    idle(2);
    snap = {pad_out, pad_oe, pad_pullup, pad_slew_limit};
    @(posedge sys_clk);
    periph_en <= ~periph_en;
    periph_oe <= ~periph_oe;
    idle(3);
    chk_frozen();
    @(posedge sys_clk);
    pd_stop <= 1'b0;
    idle(2);
    m_blk = 1'b1;
    rd(gpc_pkg::OFF_PWR, v);
    chk("pwr_wake", v, (8'h01 << gpc_pkg::PWR_FLAG_BIT)
      | (8'h01 << gpc_pkg::PWR_BLK_BIT));
    rd(gpc_pkg::OFF_DIR, v);
    chk("blocked_read", v, 8'h00);
    wr(gpc_pkg::OFF_DIR, ~m_dir);
    idle(2);
    chk_frozen();
    wr(gpc_pkg::OFF_PWR, 8'h01 << gpc_pkg::PWR_ACK_BIT);
    m_blk = 1'b0;
    idle(5);
    check_all(8'h00);
    // retained-logic stop keeps everything live
    @(posedge sys_clk);
    rt_stop <= 1'b1;
    idle(3);
    check_all(8'h01 << gpc_pkg::PWR_RET_BIT);
    @(posedge sys_clk);
    rt_stop <= 1'b0;
    idle(1);
    check_all(8'h00);
    @(posedge sys_clk);
    {periph_en, analog_en, key_in_en} <= 24'h00_0000;
    osc_en <= 1'b0;
    // pullups are off after reset, so no pin may be left floating
    ext_drv <= 8'hff;
    do_reset();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
